// [rtl/vra_pkg.sv]
// package of constants and carriers for the backplane requester, arbiter and bus timer
package vra_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned NUM_LEVELS      = 4;

  // bus timer intervals
  localparam int unsigned BTO_16_US       = 16;
  localparam int unsigned BTO_32_US       = 32;
  localparam int unsigned BTO_64_US       = 64;
  localparam int unsigned BTO_16_CYC      = (BTO_16_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned BTO_32_CYC      = (BTO_32_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned BTO_64_CYC      = (BTO_64_US * 1000) / CLK_PERIOD_NS;

  // grant low time is a longest time: round down
  localparam int unsigned GRANT_LOW_MAX_US = 17;
  localparam int unsigned GRANT_LOW_CYC    = (GRANT_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
  // recovery is a least time: round up
  localparam int unsigned RECOVER_MIN_US   = 15;
  localparam int unsigned RECOVER_CYC      =
    (RECOVER_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W            = 12;

  // timer select encodings
  localparam logic [1:0] TSEL_16           = 2'h0;
  localparam logic [1:0] TSEL_32           = 2'h1;

  typedef struct packed {
    logic       syscon;     // act as system arbiter
    logic       arb_rr;     // 1 round robin, 0 fixed priority
    logic       timer_en;   // bus timer enable
    logic [1:0] timer_sel;  // 16/32/64 us
    logic [1:0] level;      // own request level
  } vra_cfg_s;

  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_WAIT = 2'b01,
    REQ_OWN  = 2'b10
  } vra_req_state_e;

  typedef enum logic [1:0] {
    ARB_IDLE    = 2'b00,
    ARB_GRANT   = 2'b01,
    ARB_RECOVER = 2'b10
  } vra_arb_state_e;

endpackage

// [rtl/vra_top.sv]
// backplane requester, system arbiter and data-transfer bus timer
`timescale 1ns/10ps
module vra_top
  import vra_pkg::*;
#(
  parameter int unsigned TIMER_W = CNT_W
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // configuration
  input  wire vra_cfg_s              cfg,
  // local side, both active low
  input  wire logic                  local_bus_request_in,
  output logic                       local_bus_grant_out,
  // backplane request and grant lines, active low
  input  wire logic [NUM_LEVELS-1:0] br_in_n,
  output logic [NUM_LEVELS-1:0]      br_oe,
  input  wire logic [NUM_LEVELS-1:0] bg_in_n,
  output logic [NUM_LEVELS-1:0]      bg_out_n,
  // bus busy and bus clear, active low
  input  wire logic                  bbsy_in_n,
  output logic                       bbsy_oe,
  output logic                       bclr_oe,
  // data strobes and bus error, active low
  input  wire logic                  ds0_n,
  input  wire logic                  ds1_n,
  output logic                       berr_oe
);

  // refuse a timer too narrow for the longest interval or too wide for int math
  if (TIMER_W < CNT_W || TIMER_W > 31) begin : g_bad_width
    $error("vra_top: TIMER_W out of range");
  end

  localparam logic [TIMER_W-1:0] T16  = TIMER_W'(BTO_16_CYC - 1);
  localparam logic [TIMER_W-1:0] T32  = TIMER_W'(BTO_32_CYC - 1);
  localparam logic [TIMER_W-1:0] T64  = TIMER_W'(BTO_64_CYC - 1);
  localparam logic [TIMER_W-1:0] TGL  = TIMER_W'(GRANT_LOW_CYC - 1);
  localparam logic [TIMER_W-1:0] TREC = TIMER_W'(RECOVER_CYC - 1);

  // ---------------- daisy-chain grant source ----------------
  logic [NUM_LEVELS-1:0] arb_grant_n;
  wire  [NUM_LEVELS-1:0] grant_src_n = cfg.syscon ? arb_grant_n : bg_in_n;
  wire                   own_gin_n   = grant_src_n[cfg.level];
  wire                   req_active  = ~local_bus_request_in;
  wire                   bus_busy    = ~bbsy_in_n;

  // ---------------- requester ----------------
  vra_req_state_e        req_state;
  vra_req_state_e        next_req_state;
  logic                  pass_own;
  logic                  next_pass_own;
  logic                  bbsy_hold;
  wire                   req_is_wait = (req_state == REQ_WAIT);
  wire                   req_is_own  = (req_state == REQ_OWN);

  // passing a grant blocks a new request until the grant is withdrawn
  always_comb begin
    next_req_state = req_state;
    next_pass_own  = pass_own;
    case (req_state)
      REQ_IDLE: begin
        if (pass_own) begin
          next_pass_own = ~own_gin_n;
        end else if (req_active) begin
          next_req_state = REQ_WAIT;
        end else if (~own_gin_n) begin
          next_pass_own = 1'b1;
        end
      end
      REQ_WAIT: begin
        if (~req_active) begin
          next_req_state = REQ_IDLE;
        end else if (~own_gin_n) begin
          next_req_state = REQ_OWN;
        end
      end
      REQ_OWN: begin
        if (~req_active) begin
          next_req_state = REQ_IDLE;
        end
      end
      default: begin
        next_req_state = REQ_IDLE;
        next_pass_own  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_state <= REQ_IDLE;
      pass_own  <= 1'b0;
      bbsy_hold <= 1'b0;
    end else begin
      req_state <= next_req_state;
      pass_own  <= next_pass_own;
      bbsy_hold <= (next_req_state == REQ_OWN);
    end
  end

  // request line of the configured level only, driven while waiting
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LEVELS; gi++) begin : g_lvl
      wire own_lvl = (cfg.level == 2'(gi));
      assign br_oe[gi]    = own_lvl & req_is_wait;
      // own level registered, other levels straight through
      assign bg_out_n[gi] = own_lvl ? ~pass_own : grant_src_n[gi];
    end
  endgenerate

  // busy falls away as soon as the local request is withdrawn
  assign bbsy_oe             = bbsy_hold & req_active;
  assign local_bus_grant_out = ~req_is_own;

  // ---------------- system arbiter ----------------
  vra_arb_state_e        arb_state;
  vra_arb_state_e        next_arb_state;
  logic [TIMER_W-1:0]    arb_cnt;
  logic [1:0]            last_lvl;
  logic [1:0]            pick_lvl;
  logic                  bclr;
  wire  [NUM_LEVELS-1:0] pending = ~br_in_n;
  wire                   any_pending = |pending;

  // fixed priority: highest level wins; round robin: next below last grant
  function automatic logic [1:0] pick(input logic [NUM_LEVELS-1:0] p,
                                      input logic rr, input logic [1:0] last);
    logic [1:0] res;
    logic [1:0] idx;
    logic       found;
    res   = 2'h0;
    found = 1'b0;
    for (int k = NUM_LEVELS; k >= 1; k--) begin
      idx = rr ? 2'(last - 2'(NUM_LEVELS - k) - 2'h1) : 2'(k - 1);
      if (!found && p[idx]) begin
        res   = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  assign pick_lvl = pick(pending, cfg.arb_rr, last_lvl);

  // state decodes shared by the counter, the level memory and the grant lines
  logic [TIMER_W-1:0]    next_arb_cnt;
  wire                   arb_is_idle  = (arb_state == ARB_IDLE);
  wire                   arb_to_grant = (next_arb_state == ARB_GRANT);
  wire                   grant_start  = arb_is_idle & arb_to_grant;
  wire                   arb_moves    = (next_arb_state != arb_state);
  // restart on every state change so each phase times from its own start
  assign next_arb_cnt = arb_moves ? '0 : TIMER_W'(arb_cnt + 1'b1);

  // levels strictly above the one last granted, for bus clear
  logic [NUM_LEVELS-1:0] above_last;
  genvar gm;
  generate
    for (gm = 0; gm < NUM_LEVELS; gm++) begin : g_mask
      assign above_last[gm] = (2'(gm) > last_lvl);
    end
  endgenerate

  wire grant_taken   = bus_busy;
  wire grant_expired = (arb_cnt == TGL);
  wire recover_done  = (arb_cnt == TREC);
  wire higher_wait   = |(pending & above_last);
  wire next_bclr     = cfg.syscon & ~cfg.arb_rr & bus_busy & (arb_state == ARB_IDLE)
                       & higher_wait;

  always_comb begin
    next_arb_state = arb_state;
    case (arb_state)
      ARB_IDLE: begin
        if (cfg.syscon && any_pending && !bus_busy) begin
          next_arb_state = ARB_GRANT;
        end
      end
      ARB_GRANT: begin
        if (grant_taken) begin
          next_arb_state = ARB_IDLE;
        end else if (grant_expired) begin
          next_arb_state = ARB_RECOVER;
        end
      end
      ARB_RECOVER: begin
        if (recover_done) begin
          next_arb_state = ARB_IDLE;
        end
      end
      default: next_arb_state = ARB_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_state <= ARB_IDLE;
      arb_cnt   <= '0;
      last_lvl  <= 2'h0;
      bclr      <= 1'b0;
    end else begin
      arb_state <= next_arb_state;
      arb_cnt   <= next_arb_cnt;
      bclr      <= next_bclr;
      if (grant_start) begin
        last_lvl <= pick_lvl;
      end
    end
  end

  // ---------------- grant line drivers ----------------
  // fresh pick on entry, remembered level while the grant is held
  wire  [1:0]            grant_lvl = arb_is_idle ? pick_lvl : last_lvl;
  logic [NUM_LEVELS-1:0] grant_q;
  logic [NUM_LEVELS-1:0] next_grant_n;

  // grant lines from flip-flops so they only move on clock edges
  genvar gk;
  generate
    for (gk = 0; gk < NUM_LEVELS; gk++) begin : g_gnt
      wire lvl_hit = (grant_lvl == 2'(gk));
      assign next_grant_n[gk] = ~(arb_to_grant & lvl_hit);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          grant_q[gk] <= 1'b1;
        end else begin
          grant_q[gk] <= next_grant_n[gk];
        end
      end
    end
  endgenerate

  assign arb_grant_n = grant_q;
  assign bclr_oe     = bclr;

  // ---------------- data-transfer bus timer ----------------
  logic [TIMER_W-1:0] bto_cnt;
  logic [TIMER_W-1:0] next_bto_cnt;
  logic               berr;
  logic               next_berr;
  wire                ds_any  = ~ds0_n | ~ds1_n;
  wire                sel_16  = (cfg.timer_sel == TSEL_16);
  wire                sel_32  = (cfg.timer_sel == TSEL_32);
  // selects 2 and 3 both give the longest interval
  wire [TIMER_W-1:0]  bto_lim = sel_16 ? T16 : sel_32 ? T32 : T64;
  wire                bto_hit = cfg.timer_en & ds_any & (bto_cnt == bto_lim);
  wire                bto_run = ds_any & ~berr & ~bto_hit;

  // counting stops once bus error is set, so one stall fires only once
  always_comb begin
    next_bto_cnt = bto_cnt;
    next_berr    = berr;
    if (!ds_any) begin
      next_bto_cnt = '0;
      next_berr    = 1'b0;
    end else begin
      if (bto_run) begin
        next_bto_cnt = TIMER_W'(bto_cnt + 1'b1);
      end
      if (bto_hit) begin
        next_berr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bto_cnt <= '0;
      berr    <= 1'b0;
    end else begin
      bto_cnt <= next_bto_cnt;
      berr    <= next_berr;
    end
  end

  // release follows the strobes at once, not the next edge
  assign berr_oe = berr & ds_any;

endmodule

// [rtl/vra_unused_placeholder_none.sv]
// intentionally empty design unit list file
`timescale 1ns/10ps

// [tb/vra_props.sv]
// checker for the requester, arbiter and bus timer ports
`timescale 1ns/10ps
module vra_props
  import vra_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire vra_cfg_s   cfg,
  input wire logic       local_bus_request_in,
  input wire logic       local_bus_grant_out,
  input wire logic [3:0] br_in_n,
  input wire logic [3:0] br_oe,
  input wire logic [3:0] bg_in_n,
  input wire logic [3:0] bg_out_n,
  input wire logic       bbsy_in_n,
  input wire logic       bbsy_oe,
  input wire logic       bclr_oe,
  input wire logic       ds0_n,
  input wire logic       ds1_n,
  input wire logic       berr_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [3:0]   own = 4'h1 << cfg.level;
  int unsigned lim;
  logic [12:0] sc;
  logic [12:0] gc;
  assign lim = (cfg.timer_sel == TSEL_16) ? BTO_16_CYC :
               (cfg.timer_sel == TSEL_32) ? BTO_32_CYC : BTO_64_CYC;
  // strobe-low and grant-low run lengths
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sc <= 13'h0;
      gc <= 13'h0;
    end else begin
      sc <= (ds0_n && ds1_n) ? 13'h0 : sc + 13'h1;
      gc <= (&bg_out_n) ? 13'h0 : gc + 13'h1;
    end
  end
  sequence s_new_grant;
    cfg.syscon && $past(&bg_out_n) && !(&bg_out_n);
  endsequence
  AST_BR_LEVEL: assert property ((br_oe & ~own) == 4'h0)
    else $error("request driven on a foreign level");
  AST_PASS: assert property (!cfg.syscon |-> ((bg_out_n ^ bg_in_n) & ~own) == 4'h0)
    else $error("foreign grant not passed through");
  AST_BBSY_REL: assert property (local_bus_request_in |-> !bbsy_oe)
    else $error("bus busy held without request");
  AST_OWN: assert property (!local_bus_grant_out && !local_bus_request_in |-> bbsy_oe)
    else $error("local grant without bus busy");
  AST_OWN_PASS: assert property (!cfg.syscon && (bg_out_n & own) == 4'h0
    |-> local_bus_grant_out)
    else $error("own grant passed while owning");
  AST_BERR_REL: assert property (ds0_n && ds1_n |-> !berr_oe)
    else $error("bus error held after strobes high");
  AST_BERR_EARLY: assert property (berr_oe |-> sc + 2 >= lim)
    else $error("bus error too early");
  AST_GNT_MAX: assert property (cfg.syscon |-> gc <= GRANT_LOW_CYC + 1)
    else $error("grant held low too long");
  AST_NO_GNT_BUSY: assert property (s_new_grant |-> $past(bbsy_in_n))
    else $error("grant issued while bus busy");
  AST_BCLR: assert property (bclr_oe |-> cfg.syscon && !cfg.arb_rr)
    else $error("bus clear outside fixed priority arbiter");
endmodule
bind vra_top vra_props u_props (.clk(clk), .rst_n(rst_n), .cfg(cfg),
  .local_bus_request_in(local_bus_request_in), .local_bus_grant_out(local_bus_grant_out),
  .br_in_n(br_in_n), .br_oe(br_oe), .bg_in_n(bg_in_n), .bg_out_n(bg_out_n),
  .bbsy_in_n(bbsy_in_n), .bbsy_oe(bbsy_oe), .bclr_oe(bclr_oe), .ds0_n(ds0_n),
  .ds1_n(ds1_n), .berr_oe(berr_oe));

// [tb/vra_bus_model.sv]
// backplane model: wired lines and one other master
`timescale 1ns/10ps
module vra_bus_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // design side
  input  wire logic [3:0] br_oe,
  input  wire logic       bbsy_oe,
  input  wire logic [3:0] bg_out_n,
  // bench controls
  input  wire logic [3:0] ext_br,
  input  wire logic [3:0] ext_bg,
  input  wire logic       take,
  // wires seen by the design
  output logic [3:0]      br_in_n,
  output logic            bbsy_in_n,
  output logic [3:0]      bg_in_n
);
  logic busy;
  assign br_in_n   = ~(br_oe | ext_br);
  assign bbsy_in_n = ~(bbsy_oe | busy);
  assign bg_in_n   = ext_bg;
  // takes the bus one edge after its grant, like a slow board
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy <= 1'b0;
    else if (!take)
      busy <= 1'b0;
    else if (|(ext_br & ~bg_out_n))
      busy <= 1'b1;
  end
endmodule

// [tb/vra_top_test.sv]
// testbench for the backplane requester, arbiter and bus timer
`timescale 1ns/10ps
module vra_top_test
  import vra_pkg::*;
;
  logic       clk = 1'b0, rst_n = 1'b0, lreq = 1'b1, ds0 = 1'b1, ds1 = 1'b1, take = 1'b0;
  vra_cfg_s   cfg = '0;
  logic [3:0] ebr = 4'h0, ebg = 4'hf, br_oe, br_in_n, bg_in_n, bg_out_n;
  logic       bbsy_oe, bbsy_in_n, bclr_oe, berr_oe, gout;
  int         num_errors = 0, n_checks = 0, cyc = 0, n;
  always #12.5 clk = ~clk;
  vra_top u_dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .local_bus_request_in(lreq),
    .local_bus_grant_out(gout), .br_in_n(br_in_n), .br_oe(br_oe), .bg_in_n(bg_in_n),
    .bg_out_n(bg_out_n), .bbsy_in_n(bbsy_in_n), .bbsy_oe(bbsy_oe), .bclr_oe(bclr_oe),
    .ds0_n(ds0), .ds1_n(ds1), .berr_oe(berr_oe));
  vra_bus_model u_bus (.clk(clk), .rst_n(rst_n), .br_oe(br_oe), .bbsy_oe(bbsy_oe),
    .bg_out_n(bg_out_n), .ext_br(ebr), .ext_bg(ebg), .take(take), .br_in_n(br_in_n),
    .bbsy_in_n(bbsy_in_n), .bg_in_n(bg_in_n));
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_req;
    @(posedge clk);
    cfg <= 7'h01;
    lreq <= 1'b0;
    @(posedge clk) #1 chk("br_oe", br_oe, 4'h2);
    @(posedge clk);
    ebg <= 4'hc;
    #1 chk("pass_lo", bg_out_n[0], 1'b0);
    for (n = 0; n < 5 && gout !== 1'b0; n++) @(posedge clk) #1;
    chk("gout", gout, 1'b0);
    chk("bbsy", bbsy_oe, 1'b1);
    chk("br_off", br_oe, 4'h0);
    chk("own_hold", bg_out_n[1], 1'b1);
    @(posedge clk);
    lreq <= 1'b1;
    ebg[0] <= 1'b1;
    #1 chk("bbsy_rel", bbsy_oe, 1'b0);
    chk("pass_hi", bg_out_n[0], 1'b1);
    @(posedge clk) #1 chk("gout_hi", gout, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk("own_pass", bg_out_n[1], 1'b0);
    @(posedge clk);
    ebg <= 4'hf;
    $display("test req done");
  endtask
  task automatic t_timer;
    int unsigned lim [3] = '{BTO_16_CYC, BTO_32_CYC, BTO_64_CYC};
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      cfg <= {3'h1, 2'(s), 2'h1};
      ds0 <= 1'b0;
      ds1 <= 1'b0;
      for (n = 0; n < 3000 && berr_oe !== 1'b1; n++) @(posedge clk) #1;
      chk("bto", n + 2 >= lim[s] && n <= lim[s] + 2, 1'b1);
      @(posedge clk);
      ds0 <= 1'b1;
      #1 chk("berr_hold", berr_oe, 1'b1);
      @(posedge clk);
      ds1 <= 1'b1;
      #1 chk("berr_rel", berr_oe, 1'b0);
    end
    @(posedge clk);
    cfg <= 7'h01;
    ds0 <= 1'b0;
    repeat (700) @(posedge clk);
    #1 chk("bto_off", berr_oe, 1'b0);
    @(posedge clk);
    ds0 <= 1'b1;
    $display("test timer done");
  endtask
  task automatic t_arb;
    @(posedge clk);
    cfg <= 7'h40;
    ebr <= 4'h4;
    take <= 1'b1;
    for (n = 0; n < 5 && bg_out_n[2] !== 1'b0; n++) @(posedge clk) #1;
    chk("grant", bg_out_n, 4'hb);
    for (n = 0; n < 5 && bg_out_n[2] !== 1'b1; n++) @(posedge clk) #1;
    chk("taken", n < 4, 1'b1);
    @(posedge clk);
    ebr <= 4'hc;
    repeat (20) @(posedge clk);
    #1 chk("busy_hold", bg_out_n, 4'hf);
    chk("bclr", bclr_oe, 1'b1);
    @(posedge clk);
    take <= 1'b0;
    for (n = 0; n < 5 && bg_out_n[3] !== 1'b0; n++) @(posedge clk) #1;
    chk("prio", bg_out_n, 4'h7);
    chk("bclr_off", bclr_oe, 1'b0);
    // nobody takes this grant, so it must time out
    for (n = 0; n < 800 && bg_out_n[3] !== 1'b1; n++) @(posedge clk) #1;
    chk("bg_low", n >= 670 && n <= 681, 1'b1);
    for (n = 0; n < 800 && bg_out_n === 4'hf; n++) @(posedge clk) #1;
    chk("recover", n >= 600 && n <= 681, 1'b1);
    $display("test arb done");
  endtask
  task automatic t_rr;
    @(posedge clk);
    cfg  <= 7'h60;
    take <= 1'b1;
    for (n = 0; n < 5 && bg_out_n !== 4'hf; n++) @(posedge clk) #1;
    @(posedge clk);
    take <= 1'b0;
    for (n = 0; n < 5 && bg_out_n === 4'hf; n++) @(posedge clk) #1;
    chk("rr_next", bg_out_n, 4'hb);
    chk("rr_bclr", bclr_oe, 1'b0);
    $display("test rr done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_req();
    t_timer();
    t_arb();
    t_rr();
    wrap_up();
  end
endmodule
